/* verilog/qbp_pkg.sv */
package qbp_pkg;

  localparam int PORT_W = 8;
  localparam int NUM_PORTS = 4;
  localparam int PIN_W = PORT_W * NUM_PORTS;
  localparam int PULL_W = PORT_W * (NUM_PORTS - 1);

  // one phase is one oscillator period, one clk period here
  localparam int OSC_PERIOD_NS = 10;
  localparam int CLK_PERIOD_NS = 10;
  localparam int STATES_PER_CYCLE = 6;
  localparam int PHASES_PER_STATE = 2;
  localparam int OSC_PER_CYCLE = STATES_PER_CYCLE * PHASES_PER_STATE;
  localparam int CLK_PER_CYCLE =
    (OSC_PER_CYCLE * OSC_PERIOD_NS) / CLK_PERIOD_NS;
  localparam int STRONG_OSC = 2;
  localparam int STRONG_CLK = (STRONG_OSC * OSC_PERIOD_NS) / CLK_PERIOD_NS;

  localparam logic [3:0] CYC_LAST = 4'(CLK_PER_CYCLE - 1);
  // latch loaded at the end of S6P1 so the new value stands in S6P2
  localparam logic [3:0] CYC_LATCH_UPD = 4'(CLK_PER_CYCLE - 2);
  localparam logic [3:0] CYC_STRONG_END = 4'(STRONG_CLK - 1);

  localparam logic [7:0] LATCH_RESET = 8'hff;
  localparam logic [7:0] EXT_P0_FILL = 8'hff;

  typedef enum logic [1:0] {
    PORT_ZERO = 2'h0,
    PORT_ONE = 2'h1,
    PORT_TWO = 2'h2,
    PORT_THREE = 2'h3
  } qbp_port_type;

endpackage : qbp_pkg

/* verilog/qbp_timing_if.sv */
`timescale 1ns/1ns
interface qbp_timing_if;
  logic [3:0] cyc;
  logic latch_upd;
  logic buf_smp;
  logic s1_start;
  logic strong_end;
  modport src (output cyc, output latch_upd, output buf_smp,
                output s1_start, output strong_end);
  modport snk (input cyc, input latch_upd, input buf_smp,
               input s1_start, input strong_end);
endinterface : qbp_timing_if

/* verilog/qbp_timing.sv */
`timescale 1ns/1ns
module qbp_timing (
  input wire logic clk,
  input wire logic rst_n,
  qbp_timing_if.src tif
);

  logic [3:0] cyc_q;

  // position in the machine cycle: state = cyc/2 + 1, phase = cyc%2 + 1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_q <= 4'h0;
    end else if (cyc_q == qbp_pkg::CYC_LAST) begin
      cyc_q <= 4'h0;
    end else begin
      cyc_q <= cyc_q + 4'h1;
    end
  end

  assign tif.cyc = cyc_q;
  assign tif.latch_upd = (cyc_q == qbp_pkg::CYC_LATCH_UPD);
  // edges that end a phase 2 open the next phase 1 sample
  assign tif.buf_smp = cyc_q[0];
  assign tif.s1_start = (cyc_q == qbp_pkg::CYC_LAST);
  assign tif.strong_end = (cyc_q == qbp_pkg::CYC_STRONG_END);

  property p_cycle_len;
    @(posedge clk) disable iff (!rst_n)
      (cyc_q == 4'h0) |-> ##11 (cyc_q == 4'hb) ##1 (cyc_q == 4'h0);
  endproperty
  a_cycle_len: assert property (p_cycle_len)
    else $error("machine cycle is not twelve periods");

endmodule : qbp_timing

/* verilog/qbp_port_latch.sv */
`timescale 1ns/1ns
module qbp_port_latch (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] port_sel,
  input wire logic [7:0] bus_wdata,
  input wire logic wr_latch_strb,
  input wire logic rd_latch_strb,
  input wire logic rmw_rd_strb,
  input wire logic rd_pin_strb,
  output logic [7:0] bus_rdata,
  input wire logic ext_ctrl,
  input wire logic ext_hi_used,
  input wire logic [7:0] ext_addr_hi,
  input wire logic [7:0] ext_ad_out,
  input wire logic ext_ad_oe,
  input wire logic [7:0] alt_out,
  output logic [7:0] alt_in,
  input wire logic [31:0] pin_in,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe,
  output logic [23:0] strong_pullup,
  output logic [23:0] weak_latched_pullup,
  output logic [23:0] very_weak_pullup
);

  localparam int W = qbp_pkg::PORT_W;
  localparam int NP = qbp_pkg::NUM_PORTS;

  qbp_timing_if tif ();

  qbp_timing u_timing (
    .clk (clk),
    .rst_n (rst_n),
    .tif (tif.src)
  );

  logic [W-1:0] latch_q [NP];
  logic [NP-1:0] pend_q;
  logic [W-1:0] pend_data_q [NP];
  logic [31:0] pin_meta_q;
  logic [31:0] pin_sync_q;
  logic [7:0] rdata_q;
  logic [31:0] pin_out_q;
  logic [31:0] pin_oe_q;
  logic [23:0] strong_q;
  logic [23:0] strong_d;
  logic [23:0] weak_q;
  logic [23:0] vweak_q;
  logic hi_drv_q;
  logic [31:0] val;
  logic [23:0] rise;
  logic [31:0] oe_d;
  logic [31:0] out_d;
  logic ext_hi_drv;
  logic wr_now;

  assign ext_hi_drv = ext_ctrl && ext_hi_used;
  assign wr_now = wr_latch_strb && tif.latch_upd;

  // two-stage synchroniser on every pin before anything reads it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= 32'h0000_0000;
      pin_sync_q <= 32'h0000_0000;
    end else begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // a write seen early in the cycle waits here until the latch slot;
  // one pending word per port so writes to different ports do not clash
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= '0;
      for (int p = 0; p < NP; p++) begin
        pend_data_q[p] <= 8'h00;
      end
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (wr_latch_strb && !tif.latch_upd && port_sel == 2'(p)) begin
          pend_q[p] <= 1'b1;
          pend_data_q[p] <= bus_wdata;
        end else if (tif.latch_upd) begin
          pend_q[p] <= 1'b0;
        end
      end
    end
  end

  // port latches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < NP; p++) begin
        latch_q[p] <= qbp_pkg::LATCH_RESET;
      end
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (p == 0 && ext_ctrl) begin
          // external bus overwrites whatever port zero held
          latch_q[p] <= qbp_pkg::EXT_P0_FILL;
        end else if (wr_now && port_sel == 2'(p)) begin
          latch_q[p] <= bus_wdata;
        end else if (tif.latch_upd && pend_q[p]) begin
          latch_q[p] <= pend_data_q[p];
        end
      end
    end
  end

  // read path; latch reads win over pin reads
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (rd_latch_strb || rmw_rd_strb) begin
      // modify-and-write-back must see the latch, never a loaded pin
      rdata_q <= latch_q[port_sel];
    end else if (rd_pin_strb) begin
      rdata_q <= pin_sync_q[port_sel*W +: W];
    end
  end

  assign bus_rdata = rdata_q;
  assign alt_in = pin_sync_q[31:24];

  // level each buffer wants to emit
  always_comb begin
    // external bus takes the drivers away from the latches
    val[7:0] = ext_ctrl ? ext_ad_out : latch_q[0];
    val[15:8] = latch_q[1];
    val[23:16] = ext_hi_drv ? ext_addr_hi : latch_q[2];
    // latch 0 pins the alternate function low
    val[31:24] = latch_q[3] & alt_out;
  end

  assign rise = val[31:8] & ~pin_out_q[31:8];

  // strong pullup: S1P1/S1P2 on a rise, or all along for port two
  // address ones
  always_comb begin
    strong_d = strong_q;
    if (tif.s1_start) begin
      strong_d = rise;
    end else if (tif.strong_end) begin
      strong_d = '0;
    end
    if (tif.buf_smp) begin
      if (ext_hi_drv) begin
        strong_d[15:8] = ext_addr_hi;
      end else if (hi_drv_q) begin
        strong_d[15:8] = 8'h00;
      end
    end
  end

  // per-bit drive; each bit chooses its own direction, except port zero under the external bus, where ext_ad_oe sets all eight
  always_comb begin
    if (ext_ctrl) begin
      // both transistors run, so ones are driven high
      out_d[7:0] = val[7:0];
      oe_d[7:0] = {8{ext_ad_oe}};
    end else begin
      // open drain: only zeros drive, a one floats
      out_d[7:0] = 8'h00;
      oe_d[7:0] = ~latch_q[0];
    end
    out_d[31:8] = val[31:8];
    oe_d[31:8] = ~val[31:8] | strong_d;
  end

  // output buffers only look at the latch at phase 1 starts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out_q <= {8'hff, 8'hff, 8'hff, 8'h00};
      pin_oe_q <= 32'h0000_0000;
      hi_drv_q <= 1'b0;
    end else if (tif.buf_smp) begin
      pin_out_q <= out_d;
      pin_oe_q <= oe_d;
      hi_drv_q <= ext_hi_drv;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strong_q <= 24'h00_0000;
    end else begin
      strong_q <= strong_d;
    end
  end

  // very weak pullup sits on whenever the pulldown is off; the weak
  // one is kicked on by the strong pulse and held by the pin level,
  // so a glitch to 0 drops it and only the very weak one recovers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vweak_q <= 24'hff_ffff;
      weak_q <= 24'h00_0000;
    end else begin
      vweak_q <= pin_out_q[31:8];
      // the synchronised pin lags by two edges, so the pulse itself
      // keeps the latch set until the pin is seen high
      weak_q <= strong_d | strong_q |
                (weak_q & pin_sync_q[31:8] & pin_out_q[31:8]);
    end
  end

  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;
  assign strong_pullup = strong_q;
  assign weak_latched_pullup = weak_q;
  assign very_weak_pullup = vweak_q;

  property p_latch_slot;
    @(posedge clk) disable iff (!rst_n)
      (latch_q[1] != $past(latch_q[1])) |-> $past(tif.latch_upd);
  endproperty
  a_latch_slot: assert property (p_latch_slot)
    else $error("port one latch changed outside its slot");

  property p_buf_phase;
    @(posedge clk) disable iff (!rst_n)
      $changed(pin_out_q[31:8]) |-> $past(tif.buf_smp);
  endproperty
  a_buf_phase: assert property (p_buf_phase)
    else $error("pin level changed outside phase 1");

  property p_strong_s1;
    @(posedge clk) disable iff (!rst_n)
      (strong_q[7:0] != 8'h00) |-> (tif.cyc <= 4'h1);
  endproperty
  a_strong_s1: assert property (p_strong_s1)
    else $error("port one strong pullup outside state one");

  property p_strong_two;
    @(posedge clk) disable iff (!rst_n)
      $rose(|strong_q[23:16]) |-> (|strong_q[23:16]) ##1
        (|strong_q[23:16]) ##1 !(|strong_q[23:16]);
  endproperty
  a_strong_two: assert property (p_strong_two)
    else $error("strong pullup pulse not two periods");

  property p_zero_fill;
    @(posedge clk) disable iff (!rst_n)
      ext_ctrl |=> (latch_q[0] == 8'hff);
  endproperty
  a_zero_fill: assert property (p_zero_fill)
    else $error("port zero latch not filled with ones");

  property p_alt_out;
    @(posedge clk) disable iff (!rst_n)
      tif.buf_smp |=> ((pin_oe_q[31:24] & ~pin_out_q[31:24]) ==
        ~$past(latch_q[3] & alt_out));
  endproperty
  a_alt_out: assert property (p_alt_out)
    else $error("port three pin not following alternate output");

  property p_rd_latch;
    @(posedge clk) disable iff (!rst_n)
      (rd_latch_strb || rmw_rd_strb) |=>
        (rdata_q == $past(latch_q[port_sel]));
  endproperty
  a_rd_latch: assert property (p_rd_latch)
    else $error("latch read returned wrong data");

  property p_rd_pin;
    @(posedge clk) disable iff (!rst_n)
      (rd_pin_strb && !rd_latch_strb && !rmw_rd_strb) |=>
        (rdata_q == $past(pin_sync_q[port_sel*W +: W]));
  endproperty
  a_rd_pin: assert property (p_rd_pin)
    else $error("pin read returned wrong data");

  property p_zero_drain;
    @(posedge clk) disable iff (!rst_n)
      (tif.buf_smp && !ext_ctrl) |=>
        ((pin_oe_q[7:0] & pin_out_q[7:0]) == 8'h00);
  endproperty
  a_zero_drain: assert property (p_zero_drain)
    else $error("port zero drove high outside external access");

  property p_hi_hold;
    @(posedge clk) disable iff (!rst_n)
      (tif.buf_smp && ext_hi_drv) |=>
        (strong_q[15:8] == $past(ext_addr_hi));
  endproperty
  a_hi_hold: assert property (p_hi_hold)
    else $error("port two strong pullup not tracking address ones");

endmodule : qbp_port_latch

/* verif/qbp_pins_model.sv */
`timescale 1ns/1ns
module qbp_pins_model (
  input wire logic clk,
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] ext_oe,
  input wire logic [31:0] ext_val,
  output logic [31:0] pin_lvl
);
  // a floating port zero line must not look like a stable level
  logic float_q = 1'b0;

  always @(posedge clk) begin
    float_q <= ~float_q;
  end

  // design drive wins, then the outside circuit, then the pulls
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (pin_oe[i] === 1'b1) pin_lvl[i] = pin_out[i];
      else if (ext_oe[i] === 1'b1) pin_lvl[i] = ext_val[i];
      else if (i < 8) pin_lvl[i] = float_q;
      else pin_lvl[i] = 1'b1;
    end
  end
endmodule : qbp_pins_model

/* verif/quasi_bidir_port_latch_tb.sv */
`timescale 1ns/1ns
module quasi_bidir_port_latch_tb;
  logic clk, rst_n, wr_latch_strb, rd_latch_strb, rmw_rd_strb, rd_pin_strb;
  logic ext_ctrl, ext_hi_used, ext_ad_oe;
  logic [1:0] port_sel;
  logic [7:0] bus_wdata, bus_rdata, ext_addr_hi, ext_ad_out, alt_out, alt_in;
  logic [7:0] rdv;
  logic [31:0] pin_in, pin_out, pin_oe, ext_oe, ext_val;
  logic [23:0] strong_pullup, weak_latched_pullup, very_weak_pullup;
  logic [3:0] cyc;
  int failures = 0;
  int checked = 0;
  int cycles = 0;

  qbp_port_latch u_qbp_port_latch (.clk(clk), .rst_n(rst_n),
    .port_sel(port_sel), .bus_wdata(bus_wdata),
    .wr_latch_strb(wr_latch_strb), .rd_latch_strb(rd_latch_strb),
    .rmw_rd_strb(rmw_rd_strb), .rd_pin_strb(rd_pin_strb),
    .bus_rdata(bus_rdata), .ext_ctrl(ext_ctrl), .ext_hi_used(ext_hi_used),
    .ext_addr_hi(ext_addr_hi), .ext_ad_out(ext_ad_out),
    .ext_ad_oe(ext_ad_oe), .alt_out(alt_out), .alt_in(alt_in),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .strong_pullup(strong_pullup),
    .weak_latched_pullup(weak_latched_pullup),
    .very_weak_pullup(very_weak_pullup));

  qbp_pins_model u_qbp_pins_model (.clk(clk), .pin_out(pin_out),
    .pin_oe(pin_oe), .ext_oe(ext_oe), .ext_val(ext_val), .pin_lvl(pin_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // own copy of the machine cycle phase count, zero right after release
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) cyc <= 4'h0;
    else cyc <= (cyc == 4'hb) ? 4'h0 : cyc + 4'h1;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end

  task automatic conclude;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic align(input logic [3:0] n);
    tick(1);
    while (cyc !== n) tick(1);
  endtask : align

  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    port_sel = sel;
    bus_wdata = d;
    wr_latch_strb = 1'b1;
    tick(1);
    wr_latch_strb = 1'b0;
    // one idle edge so a following call never re-raises in the same step
    tick(1);
  endtask : wr

  // kind 0 latch, 1 read-modify-write, 2 pin
  task automatic rd(input logic [1:0] sel, input int k);
    port_sel = sel;
    rd_latch_strb = (k == 0);
    rmw_rd_strb = (k == 1);
    rd_pin_strb = (k == 2);
    tick(1);
    {rd_latch_strb, rmw_rd_strb, rd_pin_strb} = 3'h0;
    rdv = bus_rdata;
    tick(1);
  endtask : rd

  task automatic t_reset;
    for (int p = 0; p < 4; p++) begin
      rd(2'(p), 0);
      chk(rdv, 8'hff);
    end
    chk(pin_oe, 32'h0);
  endtask : t_reset

  task automatic t_write;
    align(4'h3);
    wr(2'h1, 8'h00);
    align(4'h9);
    rd(2'h1, 0);
    chk(rdv, 8'hff);
    chk(pin_out[15:8], 8'hff);
    tick(1);
    chk({pin_out[15:8], pin_oe[15:8]}, 16'h00ff);
    rd(2'h1, 0);
    chk(rdv, 8'h00);
    chk(very_weak_pullup[7:0], 8'h00);
    align(4'h3);
    wr(2'h1, 8'h01);
    align(4'h0);
    chk(strong_pullup[7:0], 8'h01);
    tick(1);
    chk(strong_pullup[7:0], 8'h01);
    tick(1);
    chk(strong_pullup[7:0], 8'h00);
    chk(weak_latched_pullup[7:0], 8'h01);
    chk(very_weak_pullup[7:0], 8'h01);
  endtask : t_write

  task automatic t_rdpin;
    wr(2'h1, 8'h0f);
    ext_oe = 32'h0000_0f00;
    ext_val = 32'h0000_0500;
    tick(16);
    rd(2'h1, 2);
    chk(rdv, 8'h05);
    rd(2'h1, 1);
    chk(rdv, 8'h0f);
    rd(2'h1, 0);
    chk(rdv, 8'h0f);
    ext_oe = 32'h0;
  endtask : t_rdpin

  task automatic t_ext;
    wr(2'h2, 8'h12);
    wr(2'h0, 8'h00);
    tick(14);
    chk({pin_out[7:0], pin_oe[7:0]}, 16'h00ff);
    {ext_ctrl, ext_hi_used, ext_ad_oe} = 3'h7;
    ext_addr_hi = 8'hc3;
    ext_ad_out = 8'ha5;
    tick(14);
    wr(2'h0, 8'h00);
    align(4'h2);
    chk({pin_out[7:0], pin_oe[7:0]}, 16'ha5ff);
    chk({pin_out[23:16], strong_pullup[15:8]}, 16'hc3c3);
    rd(2'h0, 0);
    chk(rdv, 8'hff);
    rd(2'h2, 0);
    chk(rdv, 8'h12);
    // an 8-bit address gives port two back to its latch
    {ext_ad_oe, ext_hi_used} = 2'h0;
    tick(2);
    chk(pin_oe[7:0], 8'h00);
    chk({pin_out[23:16], strong_pullup[15:8]}, 16'h1200);
    ext_ctrl = 1'b0;
    tick(14);
    chk({pin_out[23:16], strong_pullup[15:8]}, 16'h1200);
    chk(pin_oe[7:0], 8'h00);
  endtask : t_ext

  task automatic t_alt;
    alt_out = 8'h3c;
    tick(16);
    rd(2'h3, 2);
    chk(rdv, 8'h3c);
    chk(alt_in, 8'h3c);
    wr(2'h3, 8'h0f);
    tick(16);
    rd(2'h3, 2);
    chk(rdv, 8'h0c);
    chk(alt_in, 8'h0c);
    // ones again let bits 5:4 rise, boosted at the next S1
    wr(2'h3, 8'hff);
    align(4'h0);
    chk(strong_pullup[23:16], 8'h30);
  endtask : t_alt

  initial begin
    {rst_n, wr_latch_strb, rd_latch_strb, rmw_rd_strb, rd_pin_strb} = 5'h0;
    {ext_ctrl, ext_hi_used, ext_ad_oe} = 3'h0;
    port_sel = 2'h0;
    bus_wdata = 8'h00;
    ext_addr_hi = 8'h00;
    ext_ad_out = 8'h00;
    alt_out = 8'hff;
    ext_oe = 32'h0;
    ext_val = 32'h0;
    tick(5);
    rst_n = 1'b1;
    t_reset();
    t_write();
    t_rdpin();
    t_ext();
    t_alt();
    conclude();
  end
endmodule : quasi_bidir_port_latch_tb
